// file: common/dswp_pkg.sv
// Package of bit positions, reset values and carrier types for the status word packer.
package dswp_pkg;

	// ****************************************************************
	// Word geometry and reset values
	// ****************************************************************
	localparam int          DSWP_WORD_W      = 16;
	localparam logic [15:0] DSWP_WORD_RESET  = 16'h0000;
	localparam int          DSWP_LIFE_W      = 4;
	localparam logic [3:0]  DSWP_LIFE_RESET  = 4'h0;
	localparam logic [3:0]  DSWP_LIFE_STEP   = 4'h1;
	localparam int          DSWP_BLOCK_W     = 6;
	localparam int          DSWP_FUNC_W      = 3;
	localparam logic [2:0]  DSWP_FUNC_MIN    = 3'h1;
	localparam logic [2:0]  DSWP_FUNC_MAX    = 3'h4;
	localparam logic [2:0]  DSWP_FUNC_NONE   = 3'h0;

	// ****************************************************************
	// Primary drive status bit positions
	// ****************************************************************
	localparam int P_RDY_ON     = 0;
	localparam int P_RDY_OP     = 1;
	localparam int P_OP_EN      = 2;
	localparam int P_FAULT      = 3;
	localparam int P_NO_COAST   = 4;
	localparam int P_NO_QUICK   = 5;
	localparam int P_ON_INHIBIT = 6;
	localparam int P_ALARM      = 7;
	localparam int P_FOLLOW_OK  = 8;
	localparam int P_CTRL_REQ   = 9;
	localparam int P_TARGET     = 10;
	localparam int P_REF_SET    = 11;
	localparam int P_BLOCK_ACK  = 12;
	localparam int P_SP_FIXED   = 13;
	localparam int P_ACCEL      = 14;
	localparam int P_DECEL      = 15;

	// ****************************************************************
	// Secondary drive status bit positions
	// ****************************************************************
	localparam int S_ACLASS_LSB = 5;
	localparam int S_ACLASS_MSB = 6;
	localparam int S_ENDSTOP    = 8;
	localparam int S_PULSES     = 10;
	localparam int S_LIFE_LSB   = 12;
	localparam int S_LIFE_MSB   = 15;

	// ****************************************************************
	// Encoder one status bit positions
	// ****************************************************************
	localparam int E_FUNC_ACK   = 0;
	localparam int E_FUNC_LSB   = 1;
	localparam int E_FUNC_MSB   = 3;
	localparam int E_AVAIL_LSB  = 4;
	localparam int E_FLT_ACK    = 11;
	localparam int E_ABS_CYC    = 13;
	localparam int E_PARK       = 14;
	localparam int E_FAULT      = 15;

	// ****************************************************************
	// Drive message bit positions
	// ****************************************************************
	localparam int M_RAMP_DONE  = 0;
	localparam int M_TRQ_LOW    = 1;
	localparam int M_SPD_LT3    = 2;
	localparam int M_SPD_LE2    = 3;
	localparam int M_VDC_CTRL   = 4;
	localparam int M_NO_MOT_OT  = 6;
	localparam int M_NO_PU_OL   = 7;
	localparam int M_SPD_DEV_OK = 8;
	localparam int M_CTRL_EN    = 11;
	localparam int M_DRV_RDY    = 12;
	localparam int M_PULSES     = 13;

	// ****************************************************************
	// Positioning status one bit positions
	// ****************************************************************
	localparam int Q_BLOCK_LSB  = 0;
	localparam int Q_BLOCK_MSB  = 5;
	localparam int Q_CAM_MINUS  = 8;
	localparam int Q_CAM_PLUS   = 9;
	localparam int Q_JOG        = 10;
	localparam int Q_REF_APP    = 11;
	localparam int Q_BLOCK_MODE = 13;
	localparam int Q_SETUP      = 14;
	localparam int Q_MDI        = 15;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic       ready_switch_on;
		logic       ready_operation;
		logic       operation_enabled;
		logic       fault_present;
		logic       coast_stop_active;
		logic       quick_stop_active;
		logic       switch_on_inhibit;
		logic       alarm_present;
		logic       following_error_ok;
		logic       control_requested;
		logic       target_reached;
		logic       ref_point_set;
		logic       block_activation_ack;
		logic       setpoint_fixed;
		logic       accelerating;
		logic       decelerating;
		logic [1:0] alarm_class;
		logic       fixed_endstop;
		logic       pulses_enabled;
	} dswp_drive_t;

	typedef struct packed {
		logic       function_active;
		logic [2:0] function_num;
		logic [3:0] position_avail;
		logic       fault_ack_active;
		logic       abs_cyclic;
		logic       parking;
		logic       encoder_fault;
	} dswp_encoder_t;

	typedef struct packed {
		logic rfg_active;
		logic torque_below_thr2;
		logic speed_below_thr3;
		logic speed_at_or_below_thr2;
		logic vdc_ctrl_active;
		logic motor_overtemp_alarm;
		logic power_unit_overload_alarm;
		logic speed_dev_ok;
		logic controller_enable;
		logic drive_ready;
		logic pulses_enabled;
	} dswp_message_t;

	typedef struct packed {
		logic [5:0] active_block;
		logic       stop_cam_minus;
		logic       stop_cam_plus;
		logic       jogging;
		logic       ref_approach;
		logic       block_mode;
		logic       setup_mode;
		logic       manual_data_input;
	} dswp_position_t;

	typedef struct packed {
		logic [15:0] primary_drive_status;
		logic [15:0] secondary_drive_status;
		logic [15:0] encoder_one_status;
		logic [15:0] drive_message_status;
		logic [15:0] positioning_status_one;
	} dswp_words_t;

endpackage : dswp_pkg

// file: logic/dswp_life_counter.sv
// Four-bit slave sign-of-life counter stepped once per communication cycle.
`timescale 1ns/1ps
module dswp_life_counter
	import dswp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       step,
	output logic [3:0]      life
);

	// ****************************************************************
	// Counter
	// ****************************************************************
	logic [3:0] life_ff;
	logic [3:0] nxt_life;

	// Natural four-bit overflow gives the wrap from fifteen to zero.
	assign nxt_life = life_ff + DSWP_LIFE_STEP;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			life_ff <= DSWP_LIFE_RESET;
		else if (step)
			life_ff <= nxt_life;
	end

	assign life = life_ff;

endmodule : dswp_life_counter

// file: logic/dswp_status_packer.sv
// Top of the drive status word packer: builds the five cyclic status words.
// Summary of operation
// - Bits 0-2 show ready, operable, enabled.
// - Bits 3,6,7 show fault, inhibit, alarm.
// - Bits 4,5 high when no stops active.
// - Bit 8 following error ok, 9 control.
// - Bit 10 target reached, 11 reference set.
// - Bits 12-15 block ack, fixed, accel, decel.
// - Secondary bits 5-6 carry alarm class.
// - Secondary bit 8 endstop, 10 pulses enabled.
// - Secondary bits 12-15 carry sign-of-life.
// - Encoder bit 0 acknowledges active function.
// - Encoder bits 1-3 carry function number.
// - Encoder bits 4-7 flag position available.
// - Encoder bits 11,13,14,15 report encoder states.
// - Message bit 0 high when ramp complete.
// - Message bits 1-3 report torque, speed thresholds.
// - Message bits 4,6,7,8 report controller, thermal, deviation.
// - Message bits 11-13 enable, ready, pulses.
// - Positioning bits 0-5 carry active block.
// - Positioning bits 8,9 report stop cams.
// - Positioning bits 10,11,13-15 report active modes.
`timescale 1ns/1ps
module dswp_status_packer
	import dswp_pkg::*;
(
	input  wire logic           clk_sys,
	input  wire logic           rst_n,
	input  wire logic           cycle_strobe,
	input  dswp_drive_t         drive_in,
	input  dswp_encoder_t       encoder_in,
	input  dswp_message_t       message_in,
	input  dswp_position_t      position_in,
	output dswp_words_t         words,
	output logic                words_valid
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Only function numbers one to four exist; anything else is not reported.
	function automatic logic dswp_func_valid(input logic [2:0] num);
		dswp_func_valid = (num >= DSWP_FUNC_MIN) && (num <= DSWP_FUNC_MAX);
	endfunction : dswp_func_valid

	function automatic logic [2:0] dswp_func_report(input logic [2:0] num);
		if (dswp_func_valid(num))
			dswp_func_report = num;
		else
			dswp_func_report = DSWP_FUNC_NONE;
	endfunction : dswp_func_report

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [15:0] primary_ff;
	logic [15:0] secondary_ff;
	logic [15:0] encoder_ff;
	logic [15:0] message_ff;
	logic [15:0] position_ff;
	logic        valid_ff;
	logic [15:0] nxt_primary;
	logic [15:0] nxt_secondary;
	logic [15:0] nxt_encoder;
	logic [15:0] nxt_message;
	logic [15:0] nxt_position;
	logic [3:0]  life;
	logic [3:0]  avail_bits;

	// ****************************************************************
	// Sign-of-life
	// ****************************************************************
	// The word carries the count held at the strobe, then the count steps.
	dswp_life_counter u_life
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.step    (cycle_strobe),
		.life    (life)
	);

	// ****************************************************************
	// Encoder availability flags
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_avail
			assign avail_bits[g] = encoder_in.position_avail[g];
		end
	endgenerate

	// ****************************************************************
	// Primary drive status
	// ****************************************************************
	always_comb
	begin
		nxt_primary = DSWP_WORD_RESET;
		nxt_primary[P_RDY_ON]     = drive_in.ready_switch_on;
		nxt_primary[P_RDY_OP]     = drive_in.ready_operation;
		nxt_primary[P_OP_EN]      = drive_in.operation_enabled;
		nxt_primary[P_FAULT]      = drive_in.fault_present;
		nxt_primary[P_NO_COAST]   = ~drive_in.coast_stop_active;
		nxt_primary[P_NO_QUICK]   = ~drive_in.quick_stop_active;
		nxt_primary[P_ON_INHIBIT] = drive_in.switch_on_inhibit;
		nxt_primary[P_ALARM]      = drive_in.alarm_present;
		nxt_primary[P_FOLLOW_OK]  = drive_in.following_error_ok;
		nxt_primary[P_CTRL_REQ]   = drive_in.control_requested;
		nxt_primary[P_TARGET]     = drive_in.target_reached;
		nxt_primary[P_REF_SET]    = drive_in.ref_point_set;
		nxt_primary[P_BLOCK_ACK]  = drive_in.block_activation_ack;
		nxt_primary[P_SP_FIXED]   = drive_in.setpoint_fixed;
		nxt_primary[P_ACCEL]      = drive_in.accelerating;
		nxt_primary[P_DECEL]      = drive_in.decelerating;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			primary_ff <= DSWP_WORD_RESET;
		else if (cycle_strobe)
			primary_ff <= nxt_primary;
	end

	// ****************************************************************
	// Secondary drive status
	// ****************************************************************
	// Starting from zero keeps every reserved position cleared.
	always_comb
	begin
		nxt_secondary = DSWP_WORD_RESET;
		nxt_secondary[S_ACLASS_MSB:S_ACLASS_LSB] = drive_in.alarm_class;
		nxt_secondary[S_ENDSTOP]  = drive_in.fixed_endstop;
		nxt_secondary[S_PULSES]   = drive_in.pulses_enabled;
		nxt_secondary[S_LIFE_MSB:S_LIFE_LSB] = life;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			secondary_ff <= DSWP_WORD_RESET;
		else if (cycle_strobe)
			secondary_ff <= nxt_secondary;
	end

	// ****************************************************************
	// Encoder one status
	// ****************************************************************
	// An out-of-range function number is hidden and not acknowledged, so
	// the controller never sees a function the encoder cannot perform.
	always_comb
	begin
		nxt_encoder = DSWP_WORD_RESET;
		nxt_encoder[E_FUNC_ACK] = encoder_in.function_active
			&& dswp_func_valid(encoder_in.function_num);
		nxt_encoder[E_FUNC_MSB:E_FUNC_LSB] = dswp_func_report(encoder_in.function_num);
		nxt_encoder[E_AVAIL_LSB +: 4] = avail_bits;
		nxt_encoder[E_FLT_ACK]  = encoder_in.fault_ack_active;
		nxt_encoder[E_ABS_CYC]  = encoder_in.abs_cyclic;
		nxt_encoder[E_PARK]     = encoder_in.parking;
		nxt_encoder[E_FAULT]    = encoder_in.encoder_fault;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			encoder_ff <= DSWP_WORD_RESET;
		else if (cycle_strobe)
			encoder_ff <= nxt_encoder;
	end

	// ****************************************************************
	// Drive message status
	// ****************************************************************
	always_comb
	begin
		nxt_message = DSWP_WORD_RESET;
		nxt_message[M_RAMP_DONE]  = ~message_in.rfg_active;
		nxt_message[M_TRQ_LOW]    = message_in.torque_below_thr2;
		nxt_message[M_SPD_LT3]    = message_in.speed_below_thr3;
		nxt_message[M_SPD_LE2]    = message_in.speed_at_or_below_thr2;
		nxt_message[M_VDC_CTRL]   = message_in.vdc_ctrl_active;
		nxt_message[M_NO_MOT_OT]  = ~message_in.motor_overtemp_alarm;
		nxt_message[M_NO_PU_OL]   = ~message_in.power_unit_overload_alarm;
		nxt_message[M_SPD_DEV_OK] = message_in.speed_dev_ok;
		nxt_message[M_CTRL_EN]    = message_in.controller_enable;
		nxt_message[M_DRV_RDY]    = message_in.drive_ready;
		nxt_message[M_PULSES]     = message_in.pulses_enabled;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			message_ff <= DSWP_WORD_RESET;
		else if (cycle_strobe)
			message_ff <= nxt_message;
	end

	// ****************************************************************
	// Positioning status one
	// ****************************************************************
	always_comb
	begin
		nxt_position = DSWP_WORD_RESET;
		nxt_position[Q_BLOCK_MSB:Q_BLOCK_LSB] = position_in.active_block;
		nxt_position[Q_CAM_MINUS]  = position_in.stop_cam_minus;
		nxt_position[Q_CAM_PLUS]   = position_in.stop_cam_plus;
		nxt_position[Q_JOG]        = position_in.jogging;
		nxt_position[Q_REF_APP]    = position_in.ref_approach;
		nxt_position[Q_BLOCK_MODE] = position_in.block_mode;
		nxt_position[Q_SETUP]      = position_in.setup_mode;
		nxt_position[Q_MDI]        = position_in.manual_data_input;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			position_ff <= DSWP_WORD_RESET;
		else if (cycle_strobe)
			position_ff <= nxt_position;
	end

	// ****************************************************************
	// Word valid marker
	// ****************************************************************
	// All five words are captured on the same edge, so one marker covers
	// them and the controller never reads a mix of two cycles.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			valid_ff <= 1'b0;
		else
			valid_ff <= cycle_strobe;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign words.primary_drive_status   = primary_ff;
	assign words.secondary_drive_status = secondary_ff;
	assign words.encoder_one_status     = encoder_ff;
	assign words.drive_message_status   = message_ff;
	assign words.positioning_status_one = position_ff;
	assign words_valid                  = valid_ff;

endmodule : dswp_status_packer

// file: dv/dswp_status_packer_props.sv
// Checker of the status word packer ports.
`timescale 1ns/1ps
module dswp_status_packer_props
	import dswp_pkg::*;
(
	input  wire logic     clk_sys,
	input  wire logic     rst_n,
	input  wire logic     cycle_strobe,
	input  dswp_drive_t   drive_in,
	input  dswp_encoder_t encoder_in,
	input  dswp_message_t message_in,
	input  dswp_position_t position_in,
	input  dswp_words_t   words,
	input  wire logic     words_valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic       seen_ff;
	logic [3:0] last_ff;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			seen_ff <= 1'b0;
		else if (words_valid)
			seen_ff <= 1'b1;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			last_ff <= 4'h0;
		else if (words_valid)
			last_ff <= words.secondary_drive_status[15:12];
	end
	a_valid_follows: assert property (cycle_strobe |=> words_valid)
		else $error("valid missing after strobe");
	a_valid_cause: assert property (words_valid |-> $past(cycle_strobe))
		else $error("valid without strobe");
	a_words_hold: assert property (!cycle_strobe |=> $stable(words))
		else $error("words changed between strobes");
	a_stop_flags: assert property (cycle_strobe |=>
		words.primary_drive_status[5:4] ==
		~$past({drive_in.quick_stop_active, drive_in.coast_stop_active}))
		else $error("stop flags not inverted");
	a_fault_alarm: assert property (cycle_strobe |=>
		words.primary_drive_status[7] == $past(drive_in.alarm_present) &&
		words.primary_drive_status[3] == $past(drive_in.fault_present))
		else $error("fault or alarm bit wrong");
	a_life_step: assert property (words_valid && seen_ff |->
		words.secondary_drive_status[15:12] == last_ff + 4'h1)
		else $error("sign-of-life did not step");
	a_bad_func: assert property (cycle_strobe &&
		!(encoder_in.function_num inside {[1:4]}) |=> words.encoder_one_status[3:0] == 4'h0)
		else $error("invalid function reported");
	a_reserved_zero: assert property (words_valid |->
		((words.secondary_drive_status & 16'h0A9F) | (words.encoder_one_status & 16'h1700)
		| (words.drive_message_status & 16'hC620)
		| (words.positioning_status_one & 16'h10C0)) == 16'h0000)
		else $error("reserved bit set");
	a_block_number: assert property (cycle_strobe |=>
		words.positioning_status_one[5:0] == $past(position_in.active_block))
		else $error("block number wrong");
	a_ramp_invert: assert property (cycle_strobe |=>
		words.drive_message_status[0] != $past(message_in.rfg_active))
		else $error("ramp bit not inverted");
	c_back_to_back: cover property (cycle_strobe ##1 cycle_strobe);
	c_life_wrap: cover property (words_valid && words.secondary_drive_status[15:12] == 4'hF);
	c_bad_func: cover property (cycle_strobe && encoder_in.function_num > 3'h4);
endmodule : dswp_status_packer_props

bind dswp_status_packer dswp_status_packer_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
	.cycle_strobe(cycle_strobe), .drive_in(drive_in), .encoder_in(encoder_in),
	.message_in(message_in), .position_in(position_in), .words(words),
	.words_valid(words_valid));

// file: dv/dswp_ctrl_model.sv
// Controller model that issues communication cycles and watches the sign-of-life.
`timescale 1ns/1ps
module dswp_ctrl_model
	import dswp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       en,
	input  wire logic [3:0] gap,
	input  dswp_words_t     words,
	input  wire logic       words_valid,
	output logic            cycle_strobe,
	output logic            life_err
);
	logic [3:0] cnt_ff;
	logic [3:0] life_ff;
	logic       seen_ff;
	// A gap of zero strobes every cycle, the densest order allowed.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= 4'h0;
			cycle_strobe <= 1'b0;
		end
		else
		begin
			cycle_strobe <= en && (cnt_ff == 4'h0);
			cnt_ff <= (cnt_ff == 4'h0) ? gap : cnt_ff - 4'h1;
		end
	end
	// A stalled drive shows a sign-of-life that failed to step; the flag stays set.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seen_ff <= 1'b0;
			life_ff <= 4'h0;
			life_err <= 1'b0;
		end
		else if (words_valid)
		begin
			seen_ff <= 1'b1;
			life_ff <= words.secondary_drive_status[15:12];
			if (seen_ff && words.secondary_drive_status[15:12] != life_ff + 4'h1)
				life_err <= 1'b1;
		end
	end
endmodule : dswp_ctrl_model

// file: dv/test_dswp_status_packer.sv
// Self-checking bench for the status word packer.
`timescale 1ns/1ps
module test_dswp_status_packer
	import dswp_pkg::*;
;
	logic           clk_sys, rst_n, rand_en, ctrl_en, cycle_strobe, words_valid, life_err;
	logic           dir_en;
	logic [2:0]     dir_num;
	logic [3:0]     gap;
	logic [63:0]    rnd;
	dswp_drive_t    d_in = '0;
	dswp_encoder_t  e_in = '0;
	dswp_message_t  m_in = '0;
	dswp_position_t p_in = '0;
	dswp_words_t    words;
	dswp_words_t    exp_q[$];
	int             life, n_errors, tests_run, i;
	int             mpos[11] = '{0, 1, 2, 3, 4, 6, 7, 8, 11, 12, 13};

	dswp_status_packer dut (.clk_sys(clk_sys), .rst_n(rst_n), .cycle_strobe(cycle_strobe),
		.drive_in(d_in), .encoder_in(e_in), .message_in(m_in), .position_in(p_in),
		.words(words), .words_valid(words_valid));
	dswp_ctrl_model u_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .en(ctrl_en), .gap(gap),
		.words(words), .words_valid(words_valid), .cycle_strobe(cycle_strobe),
		.life_err(life_err));

	// ****************************************************************
	// Reference model
	// ****************************************************************
	function automatic dswp_words_t model(input logic [3:0] lf);
		dswp_words_t w;
		logic        ok;
		ok = (e_in.function_num >= 3'h1) && (e_in.function_num <= 3'h4);
		w = '0;
		for (int k = 0; k < 16; k++)
			w.primary_drive_status[k] = d_in[19 - k];
		w.primary_drive_status ^= 16'h0030;
		w.secondary_drive_status = {lf, 1'h0, d_in.pulses_enabled, 1'h0, d_in.fixed_endstop,
			1'h0, d_in.alarm_class, 5'h00};
		w.encoder_one_status = {e_in.encoder_fault, e_in.parking, e_in.abs_cyclic, 1'h0,
			e_in.fault_ack_active, 3'h0, e_in.position_avail,
			ok ? e_in.function_num : 3'h0, ok & e_in.function_active};
		for (int k = 0; k < 11; k++)
			w.drive_message_status[mpos[k]] = m_in[10 - k];
		w.drive_message_status ^= 16'h00C1;
		w.positioning_status_one = {p_in.manual_data_input, p_in.setup_mode, p_in.block_mode,
			1'h0, p_in.ref_approach, p_in.jogging, p_in.stop_cam_plus, p_in.stop_cam_minus,
			2'h0, p_in.active_block};
		return w;
	endfunction : model

	task automatic fail(input string msg);
		$display("FAIL %0t: %s", $time, msg);
		n_errors++;
	endtask : fail

	task automatic results;
		$display("checks %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	// Stops the cycles, then waits a bounded time for every expected word to arrive.
	task automatic drain;
		int t;
		ctrl_en <= 1'b0;
		// Strobes already launched need two edges to come back as words.
		repeat (3) @(posedge clk_sys);
		#1;
		for (t = 0; t < 20 && exp_q.size() != 0; t++)
		begin
			@(posedge clk_sys);
			#1;
		end
		tests_run++;
		if (exp_q.size() != 0 || life_err !== 1'b0)
		begin
			fail("words missing or sign-of-life stalled");
			results();
		end
		@(posedge clk_sys);
	endtask : drain

	task automatic reset_for(input int n);
		rst_n <= 1'b0;
		repeat (n) @(posedge clk_sys);
		#1;
		tests_run++;
		if (words !== '0 || words_valid !== 1'b0)
			fail("outputs not cleared in reset");
		@(posedge clk_sys);
		rst_n <= 1'b1;
	endtask : reset_for

	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
		if (rand_en)
		begin
			rnd = {$urandom, $urandom};
			d_in <= rnd[19:0];
			e_in <= rnd[31:20];
			m_in <= rnd[42:32];
			p_in <= rnd[55:43];
		end
		else if (dir_en)
			e_in <= {1'h1, dir_num, 8'hA5};

	always @(posedge clk_sys)
		if (!rst_n)
		begin
			exp_q.delete();
			life = 0;
		end
		else
		begin
			if (words_valid === 1'b1)
			begin
				tests_run++;
				if (exp_q.size() == 0 || words !== exp_q[0])
					fail("status words differ from model");
				if (exp_q.size() != 0)
					void'(exp_q.pop_front());
			end
			if (cycle_strobe === 1'b1)
			begin
				exp_q.push_back(model(life[3:0]));
				life = (life + 1) % 16;
			end
		end

	initial
	begin
		rand_en = 1'b0;
		ctrl_en = 1'b0;
		dir_en = 1'b0;
		dir_num = 3'h0;
		gap = 4'h0;
		n_errors = 0;
		tests_run = 0;
		void'($urandom(66));
		reset_for(4);
		rand_en <= 1'b1;
		ctrl_en <= 1'b1;
		repeat (40) @(posedge clk_sys);
		gap <= 4'h5;
		repeat (120) @(posedge clk_sys);
		drain();
		rand_en <= 1'b0;
		gap <= 4'h0;
		ctrl_en <= 1'b1;
		// Let the cycle counter run out its old gap so every number is captured.
		repeat (6) @(posedge clk_sys);
		dir_en <= 1'b1;
		for (i = 0; i < 8; i++)
		begin
			dir_num <= i[2:0];
			@(posedge clk_sys);
		end
		dir_en <= 1'b0;
		drain();
		rand_en <= 1'b1;
		ctrl_en <= 1'b1;
		repeat (30) @(posedge clk_sys);
		reset_for(2);
		ctrl_en <= 1'b1;
		repeat (40) @(posedge clk_sys);
		drain();
		results();
	end
endmodule : test_dswp_status_packer
